/* File: core/dsc_host.sv */
// Host controller for the DAC three-wire and two-wire control ports.
`timescale 1ns/10ps
`default_nettype none

module dsc_host (
	input  wire logic               clk,                // Host clock.
	input  wire logic               rst_b,              // Async reset.
	input  wire logic               fast_mode,          // Two-wire speed.
	input  wire logic               req_valid,          // Request offered.
	output logic                    req_ready,          // Request taken.
	input  wire dsc_pkg::dsc_req_type req,              // Request fields.
	input  wire logic               wr_valid,           // Data byte offered.
	output logic                    wr_ready,           // Data byte taken.
	input  wire logic [7:0]         wr_data,            // Data byte.
	output logic                    rsp_valid,          // Transfer done.
	output dsc_pkg::dsc_rsp_type    rsp,                // Done report.
	output logic                    ctl_select_n,       // Three-wire select.
	output logic                    ctl_shift_clock,    // Three-wire clock.
	output logic                    ctl_serial_data_in, // Three-wire data.
	input  wire logic               scl_i,              // Clock line level.
	output logic                    scl_o,              // Clock drive value.
	output logic                    scl_oe_n,           // Clock drive enable.
	input  wire logic               sda_i,              // Data line level.
	output logic                    sda_o,              // Data drive value.
	output logic                    sda_oe_n            // Data drive enable.
);

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_SPI_LEAD,
		ST_SPI_BIT,
		ST_SPI_TAIL,
		ST_SPI_GAP,
		ST_I2C_START,
		ST_I2C_BIT,
		ST_I2C_FETCH,
		ST_I2C_STOP
	} dsc_state_type;

	typedef enum logic [2:0] {
		PH_ADDR_W,
		PH_REG,
		PH_DATA,
		PH_ADDR_R,
		PH_READ
	} dsc_phase_type;

	localparam int TW = dsc_pkg::TMR_W;

	dsc_state_type        st_r,    st_nxt;
	dsc_phase_type        ph_r,    ph_nxt;
	dsc_pkg::dsc_req_type req_r,   req_nxt;
	dsc_pkg::dsc_rsp_type rsp_r,   rsp_nxt;
	logic [TW-1:0]        tmr_r,   tmr_nxt;
	logic [1:0]           q_r,     q_nxt;
	logic [3:0]           bit_r,   bit_nxt;
	logic [4:0]           cnt_r,   cnt_nxt;
	logic [7:0]           sh_r,    sh_nxt;
	logic [7:0]           rx_r,    rx_nxt;
	logic                 ack_r,   ack_nxt;
	logic                 nack_r,  nack_nxt;
	logic                 sel_r,   sel_nxt;
	logic                 sck_r,   sck_nxt;
	logic                 sdo_r,   sdo_nxt;
	logic                 scl_r,   scl_nxt;
	logic                 sda_r,   sda_nxt;
	logic                 done_r,  done_nxt;
	logic                 scl_m_r, scl_s_r;
	logic                 sda_m_r, sda_s_r;

	// Decode of timers, lengths and the bytes that open each phase.
	wire                  tmr_done  = (tmr_r == '0);
	wire  [TW-1:0]        q_len     = fast_mode ? dsc_pkg::FAST_Q_CYC
	                                            : dsc_pkg::STD_Q_CYC;
	wire  [6:0]           addr7     = {req_r.dev, req_r.reg_base};
	wire  [7:0]           spi_head  = {dsc_pkg::WR_FLAG, req.dev,
	                                   req.reg_base};
	wire  [7:0]           slv_w     = {dsc_pkg::SLAVE_HI, req.dev,
	                                   dsc_pkg::DIR_WRITE};
	wire  [7:0]           slv_r     = {dsc_pkg::SLAVE_HI, req_r.dev,
	                                   dsc_pkg::DIR_READ};
	wire  [4:0]           nb_req    = {1'b0, req.nbytes_m1} + 5'h01;
	wire  [4:0]           nb_spi    = (nb_req > dsc_pkg::SPI_MAX_DATA)
	                                  ? dsc_pkg::SPI_MAX_DATA : nb_req;
	wire                  last_bit  = (bit_r[2:0] == dsc_pkg::LAST_BIT);
	wire                  ack_slot  = (bit_r == dsc_pkg::ACK_SLOT);
	wire                  sda_rel   = (ph_r == PH_READ) || ack_slot;
	wire                  scl_high  = scl_s_r;
	wire                  got_nack  = (ack_r != dsc_pkg::ACK_LEVEL);

	// Open-drain lines only ever pull low; release lets the pull-up win.
	assign scl_o              = 1'b0;
	assign sda_o              = 1'b0;
	assign scl_oe_n           = scl_r;
	assign sda_oe_n           = sda_r;
	assign ctl_select_n       = sel_r;
	assign ctl_shift_clock    = sck_r;
	assign ctl_serial_data_in = sdo_r;
	assign rsp_valid          = done_r;
	assign rsp                = rsp_r;
	assign req_ready          = (st_r == ST_IDLE);

	always_comb begin
		st_nxt   = st_r;
		ph_nxt   = ph_r;
		req_nxt  = req_r;
		rsp_nxt  = rsp_r;
		tmr_nxt  = tmr_done ? tmr_r : tmr_r - {{(TW-1){1'b0}}, 1'b1};
		q_nxt    = q_r;
		bit_nxt  = bit_r;
		cnt_nxt  = cnt_r;
		sh_nxt   = sh_r;
		rx_nxt   = rx_r;
		ack_nxt  = ack_r;
		nack_nxt = nack_r;
		sel_nxt  = sel_r;
		sck_nxt  = sck_r;
		sdo_nxt  = sdo_r;
		scl_nxt  = scl_r;
		sda_nxt  = sda_r;
		done_nxt = 1'b0;
		wr_ready = 1'b0;
		unique case (st_r)
			ST_IDLE: begin
				if (req_valid) begin
					req_nxt  = req;
					nack_nxt = 1'b0;
					q_nxt    = 2'h0;
					bit_nxt  = 4'h0;
					if (req.use_i2c) begin
						st_nxt  = ST_I2C_START;
						ph_nxt  = PH_ADDR_W;
						sh_nxt  = slv_w;
						cnt_nxt = nb_req;
						tmr_nxt = q_len;
					end else begin
						st_nxt  = ST_SPI_LEAD;
						sel_nxt = 1'b0;
						sh_nxt  = spi_head;
						cnt_nxt = nb_spi;
						tmr_nxt = dsc_pkg::MSS_CYC;
					end
				end
			end
			ST_SPI_LEAD: begin
				if (tmr_done) begin
					st_nxt  = ST_SPI_BIT;
					sdo_nxt = sh_r[7];
					tmr_nxt = dsc_pkg::SCK_HALF_CYC;
				end
			end
			ST_SPI_BIT: begin
				if (tmr_done && q_r == 2'h0) begin
					sck_nxt = 1'b1;
					q_nxt   = 2'h1;
					tmr_nxt = dsc_pkg::SCK_HALF_CYC;
				end else if (tmr_done && !last_bit) begin
					bit_nxt = bit_r + 4'h1;
					sh_nxt  = {sh_r[6:0], 1'b0};
					sdo_nxt = sh_r[6];
					sck_nxt = 1'b0;
					q_nxt   = 2'h0;
					tmr_nxt = dsc_pkg::SCK_HALF_CYC;
				end else if (tmr_done && cnt_r == 5'h00) begin
					// The last pulse is finished before select rises.
					st_nxt  = ST_SPI_TAIL;
					sck_nxt = 1'b0;
					tmr_nxt = dsc_pkg::MSH_CYC;
				end else if (tmr_done && wr_valid) begin
					// Clock is held high while no byte is offered.
					wr_ready = 1'b1;
					sh_nxt   = wr_data;
					sdo_nxt  = wr_data[7];
					cnt_nxt  = cnt_r - 5'h01;
					bit_nxt  = 4'h0;
					sck_nxt  = 1'b0;
					q_nxt    = 2'h0;
					tmr_nxt  = dsc_pkg::SCK_HALF_CYC;
				end
			end
			ST_SPI_TAIL: begin
				if (tmr_done) begin
					sel_nxt = 1'b1;
					sck_nxt = 1'b0;
					st_nxt  = ST_SPI_GAP;
					tmr_nxt = dsc_pkg::MHH_CYC;
				end
			end
			ST_SPI_GAP: begin
				if (tmr_done) begin
					st_nxt   = ST_IDLE;
					done_nxt = 1'b1;
					rsp_nxt  = '{nack: 1'b0, rd_data: 8'h00};
				end
			end
			ST_I2C_START: begin
				// Quarters: release data, raise clock, pull data, drop clock.
				if (tmr_done) begin
					tmr_nxt = q_len;
					q_nxt   = q_r + 2'h1;
					unique case (q_r)
						2'h0: sda_nxt = 1'b1;
						2'h1: scl_nxt = 1'b1;
						2'h2: sda_nxt = 1'b0;
						2'h3: begin
							scl_nxt = 1'b0;
							bit_nxt = 4'h0;
							st_nxt  = ST_I2C_BIT;
						end
					endcase
				end
			end
			ST_I2C_BIT: begin
				if (tmr_done && q_r == 2'h0) begin
					sda_nxt = sda_rel ? 1'b1 : sh_r[7];
					q_nxt   = 2'h1;
					tmr_nxt = q_len;
				end else if (tmr_done && q_r == 2'h1) begin
					scl_nxt = 1'b1;
					q_nxt   = 2'h2;
					tmr_nxt = q_len;
				end else if (tmr_done && q_r == 2'h2 && scl_high) begin
					// Waiting on the line level honours slave stretching.
					if (ack_slot) begin
						ack_nxt = sda_s_r;
					end else begin
						rx_nxt = {rx_r[6:0], sda_s_r};
					end
					q_nxt   = 2'h3;
					tmr_nxt = q_len;
				end else if (tmr_done && q_r == 2'h3) begin
					scl_nxt = 1'b0;
					q_nxt   = 2'h0;
					tmr_nxt = q_len;
					if (!ack_slot) begin
						bit_nxt = bit_r + 4'h1;
						sh_nxt  = {sh_r[6:0], 1'b0};
					end else if (ph_r == PH_READ) begin
						st_nxt = ST_I2C_STOP;
					end else if (got_nack) begin
						nack_nxt = 1'b1;
						st_nxt   = ST_I2C_STOP;
					end else begin
						bit_nxt = 4'h0;
						unique case (ph_r)
							PH_ADDR_W: begin
								ph_nxt = PH_REG;
								sh_nxt = {1'b0, addr7};
							end
							PH_REG: begin
								if (req_r.rd) begin
									ph_nxt = PH_ADDR_R;
									sh_nxt = slv_r;
									st_nxt = ST_I2C_START;
								end else begin
									ph_nxt = PH_DATA;
									st_nxt = ST_I2C_FETCH;
								end
							end
							PH_DATA: begin
								// Device advances and wraps its own index.
								st_nxt = (cnt_r == 5'h00) ? ST_I2C_STOP
								                          : ST_I2C_FETCH;
							end
							PH_ADDR_R: ph_nxt = PH_READ;
							PH_READ:   st_nxt = ST_I2C_STOP;
						endcase
					end
				end
			end
			ST_I2C_FETCH: begin
				// Clock stays low, so the bus waits on the byte source.
				if (wr_valid) begin
					wr_ready = 1'b1;
					sh_nxt   = wr_data;
					cnt_nxt  = cnt_r - 5'h01;
					q_nxt    = 2'h0;
					tmr_nxt  = q_len;
					st_nxt   = ST_I2C_BIT;
				end
			end
			ST_I2C_STOP: begin
				if (tmr_done) begin
					tmr_nxt = q_len;
					q_nxt   = q_r + 2'h1;
					unique case (q_r)
						2'h0: sda_nxt = 1'b0;
						2'h1: scl_nxt = 1'b1;
						2'h2: sda_nxt = 1'b1;
						2'h3: begin
							st_nxt   = ST_IDLE;
							done_nxt = 1'b1;
							rsp_nxt  = '{nack: nack_r, rd_data: rx_r};
						end
					endcase
				end
			end
			default: st_nxt = ST_IDLE;
		endcase
	end

	// Line inputs come from another domain, so two flops precede any use.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			scl_m_r <= 1'b1;
			scl_s_r <= 1'b1;
			sda_m_r <= 1'b1;
			sda_s_r <= 1'b1;
		end else begin
			scl_m_r <= scl_i;
			scl_s_r <= scl_m_r;
			sda_m_r <= sda_i;
			sda_s_r <= sda_m_r;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_r   <= ST_IDLE;
			ph_r   <= PH_ADDR_W;
			req_r  <= '0;
			rsp_r  <= '0;
			tmr_r  <= '0;
			q_r    <= 2'h0;
			bit_r  <= 4'h0;
			cnt_r  <= 5'h00;
			sh_r   <= 8'h00;
			rx_r   <= 8'h00;
			ack_r  <= 1'b1;
			nack_r <= 1'b0;
			sel_r  <= 1'b1;
			sck_r  <= 1'b0;
			sdo_r  <= 1'b0;
			scl_r  <= 1'b1;
			sda_r  <= 1'b1;
			done_r <= 1'b0;
		end else begin
			st_r   <= st_nxt;
			ph_r   <= ph_nxt;
			req_r  <= req_nxt;
			rsp_r  <= rsp_nxt;
			tmr_r  <= tmr_nxt;
			q_r    <= q_nxt;
			bit_r  <= bit_nxt;
			cnt_r  <= cnt_nxt;
			sh_r   <= sh_nxt;
			rx_r   <= rx_nxt;
			ack_r  <= ack_nxt;
			nack_r <= nack_nxt;
			sel_r  <= sel_nxt;
			sck_r  <= sck_nxt;
			sdo_r  <= sdo_nxt;
			scl_r  <= scl_nxt;
			sda_r  <= sda_nxt;
			done_r <= done_nxt;
		end
	end

endmodule : dsc_host

`default_nettype wire

/* File: core/dsc_pkg.sv */
// Shared constants and carrier types for the DAC serial control host.
package dsc_pkg;

	// Host clock period.
	localparam int CLK_PERIOD_NS = 10;
	localparam int TMR_W         = 10;

	// Three-wire port timing, least times in nanoseconds.
	localparam int SCK_HALF_NS = 50;
	localparam int MSS_NS      = 30;
	localparam int MSH_NS      = 15;
	localparam int MHH_NS      = 100;

	localparam logic [TMR_W-1:0] SCK_HALF_CYC =
		TMR_W'((SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [TMR_W-1:0] MSS_CYC =
		TMR_W'((MSS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [TMR_W-1:0] MSH_CYC =
		TMR_W'((MSH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [TMR_W-1:0] MHH_CYC =
		TMR_W'((MHH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// Two-wire quarter bit periods, least times in nanoseconds.
	localparam int FAST_Q_NS = 650;
	localparam int STD_Q_NS  = 4700;

	localparam logic [TMR_W-1:0] FAST_Q_CYC =
		TMR_W'((FAST_Q_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [TMR_W-1:0] STD_Q_CYC =
		TMR_W'((STD_Q_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// Word layout and protocol levels.
	localparam logic       WR_FLAG      = 1'h0;
	localparam logic       DIR_READ     = 1'h1;
	localparam logic       DIR_WRITE    = 1'h0;
	localparam logic       ACK_LEVEL    = 1'h0;
	localparam logic [4:0] SLAVE_HI     = 5'h13;
	localparam logic [2:0] LAST_BIT     = 3'h7;
	localparam logic [3:0] ACK_SLOT     = 4'h8;
	localparam logic [4:0] SPI_MAX_DATA = 5'h0a;

	typedef enum logic {
		ST_ZERO_DUMMY
	} dsc_unused_type;

	// One request: target device, base register and data byte count.
	typedef struct packed {
		logic       use_i2c;
		logic       rd;
		logic [1:0] dev;
		logic [4:0] reg_base;
		logic [3:0] nbytes_m1;
	} dsc_req_type;

	// Completion report.
	typedef struct packed {
		logic       nack;
		logic [7:0] rd_data;
	} dsc_rsp_type;

endpackage : dsc_pkg

/* File: tb/dsc_dev_model.sv */
// Behavioural model of the DAC control ports, both serial kinds.
`timescale 1ns/10ps
`default_nettype none

module dsc_dev_model #(
	parameter logic [1:0] DEV = 2'h1
) (
	input  wire logic ctl_select_n,       // Three-wire select.
	input  wire logic ctl_shift_clock,    // Three-wire clock.
	input  wire logic ctl_serial_data_in, // Three-wire data.
	input  wire logic scl,                // Two-wire clock level.
	input  wire logic sda,                // Two-wire data level.
	output logic      sda_pull            // High pulls data low.
);
	logic [7:0]  mem [128];
	logic [15:0] sr3;
	logic [7:0]  sr, pd;
	logic [6:0]  pa, idx;
	logic        pend = 1'h0, rw = 1'h0, act = 1'h0;
	int          cnt = 0, pos = 0, byten = 0;

	function automatic logic reg_known(input logic [6:0] a);
		return a[6:5] == DEV && a[4:0] >= 5'h10 && a[4:0] <= 5'h19;
	endfunction : reg_known

	initial begin
		foreach (mem[i]) mem[i] = 8'h00;
		sda_pull = 1'h0;
	end

	// Only host pins clock this logic, so audio clocks cannot disturb it.
	always @(negedge ctl_select_n) begin
		cnt = 0;
		pend = 1'h0;
	end
	always @(posedge ctl_shift_clock) if (!ctl_select_n) begin
		sr3 = {sr3[14:0], ctl_serial_data_in};
		cnt++;
		if (cnt == 16) begin
			pa = sr3[14:8];
			pd = sr3[7:0];
			pend = !sr3[15] && sr3[14:13] == DEV;
		end else if (cnt > 16 && cnt <= 88 && cnt % 8 == 0 && pend) begin
			mem[pa] = pd;
			pa = pa + 7'h01;
			pd = sr3[7:0];
		end
	end
	// A frame cut short before its sixteenth clock never stages a byte.
	always @(posedge ctl_select_n) begin
		if (pend) mem[pa] = pd;
		pend = 1'h0;
	end

	always @(negedge sda) if (scl) begin
		act = 1'h1;
		pos = 0;
		byten = 0;
		sda_pull = 1'h0;
	end
	always @(posedge sda) if (scl) begin
		act = 1'h0;
		sda_pull = 1'h0;
	end
	always @(posedge scl) if (act) begin
		pos++;
		if (pos <= 8) sr = {sr[6:0], sda};
		else if (rw && byten > 0 && sda) act = 1'h0;
	end
	always @(negedge scl) if (act) begin
		if (pos == 8) begin
			if (byten == 0) begin
				rw = sr[0];
				act = sr[7:1] == {5'h13, DEV};
				sda_pull = act;
			end else if (rw) begin
				sda_pull = 1'h0;
			end else if (byten == 1) begin
				idx = sr[6:0];
				sda_pull = reg_known(idx);
			end else begin
				sda_pull = reg_known(idx);
				if (reg_known(idx)) mem[idx] = sr;
				idx = (idx == 7'h4f) ? 7'h40 : idx + 7'h01;
			end
		end else if (pos == 9) begin
			pos = 0;
			byten++;
			sda_pull = rw && !mem[idx][7];
		end else if (rw && byten > 0) begin
			sda_pull = !mem[idx][7 - pos];
		end
	end
endmodule : dsc_dev_model
`default_nettype wire

/* File: tb/dsc_host_checker.sv */
// Assertion checker on the pins of the DAC control port host.
`timescale 1ns/10ps
`default_nettype none

module dsc_host_checker (
	input wire logic                 clk,                // Clock.
	input wire logic                 rst_b,              // Reset.
	input wire logic                 fast_mode,          // Speed.
	input wire logic                 req_valid,          // Offer.
	input wire logic                 req_ready,          // Taken.
	input wire dsc_pkg::dsc_req_type req,                // Request.
	input wire logic                 wr_valid,           // Byte offer.
	input wire logic                 wr_ready,           // Byte taken.
	input wire logic [7:0]           wr_data,            // Byte.
	input wire logic                 rsp_valid,          // Done.
	input wire dsc_pkg::dsc_rsp_type rsp,                // Report.
	input wire logic                 ctl_select_n,       // Select.
	input wire logic                 ctl_shift_clock,    // Shift clock.
	input wire logic                 ctl_serial_data_in, // Serial data.
	input wire logic                 scl_i,              // Clock line.
	input wire logic                 scl_o,              // Clock value.
	input wire logic                 scl_oe_n,           // Clock enable.
	input wire logic                 sda_i,              // Data line.
	input wire logic                 sda_o,              // Data value.
	input wire logic                 sda_oe_n            // Data enable.
);
	default clocking dck @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	chk_idle_clock_low: assert property (
		ctl_select_n |-> !ctl_shift_clock)
		else $error("Shift clock high while deselected.");
	chk_select_lead: assert property (
		$fell(ctl_select_n) |-> !ctl_shift_clock [*3])
		else $error("Shift clock rose too soon after select.");
	chk_select_rise: assert property (
		$rose(ctl_select_n) |-> !$past(ctl_shift_clock))
		else $error("Select rose while shift clock high.");
	chk_select_gap: assert property (
		$rose(ctl_select_n) |-> ctl_select_n [*8])
		else $error("Select high time too short.");
	chk_data_steady: assert property (
		ctl_shift_clock |-> $stable(ctl_serial_data_in))
		else $error("Serial data moved while shift clock high.");
	chk_port_exclusive: assert property (
		!ctl_select_n |-> scl_oe_n && sda_oe_n)
		else $error("Two-wire lines driven during a three-wire frame.");
	chk_busy_refuse: assert property (
		!ctl_select_n |-> !req_ready)
		else $error("Request offered ready during a frame.");
	chk_rsp_pulse: assert property (
		rsp_valid |=> !rsp_valid)
		else $error("Completion longer than one cycle.");
	chk_rsp_idle: assert property (
		rsp_valid |=> req_ready)
		else $error("Host not idle after completion.");

	cov_select_rise: cover property ($rose(ctl_select_n));
	cov_nack: cover property (rsp_valid && rsp.nack);
	cov_start: cover property ($fell(sda_oe_n) && scl_oe_n);
endmodule : dsc_host_checker

bind dsc_host dsc_host_checker chk (
	.clk(clk), .rst_b(rst_b), .fast_mode(fast_mode),
	.req_valid(req_valid), .req_ready(req_ready), .req(req),
	.wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
	.rsp_valid(rsp_valid), .rsp(rsp), .ctl_select_n(ctl_select_n),
	.ctl_shift_clock(ctl_shift_clock),
	.ctl_serial_data_in(ctl_serial_data_in), .scl_i(scl_i),
	.scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_i(sda_i), .sda_o(sda_o),
	.sda_oe_n(sda_oe_n)
);
`default_nettype wire

/* File: tb/test_dac_serial_control_port.sv */
// Self-checking bench for the DAC control port host.
`timescale 1ns/10ps
`default_nettype none

module test_dac_serial_control_port;
	typedef struct {
		logic                 fm;
		dsc_pkg::dsc_req_type rq;
		logic [7:0]           d0;
		logic [7:0]           nb;
		logic                 nk;
		logic [7:0]           rdx;
		logic                 clr;
	} dsc_row_type;

	logic                 clk, rst_b, fast_mode, req_valid, wr_valid;
	logic                 req_ready, wr_ready, rsp_valid, sda_pull;
	logic                 ctl_select_n, ctl_shift_clock, ctl_serial_data_in;
	logic                 scl_o, scl_oe_n, sda_o, sda_oe_n;
	logic [7:0]           d0, t0;
	logic [7:0]           taken = 8'h00;
	dsc_pkg::dsc_req_type req;
	dsc_pkg::dsc_rsp_type rsp;
	dsc_row_type          rows [7];
	dsc_row_type          stall_row;
	wire logic [7:0]      wr_data;
	wire logic            scl_i, sda_i;
	int                   n_errors = 0, check_count = 0, cyc = 0;

	// Both lines have pull-ups; a released line reads high.
	assign scl_i = scl_oe_n ? 1'h1 : scl_o;
	assign sda_i = (sda_oe_n ? 1'h1 : sda_o) & !sda_pull;
	assign wr_data = 8'(d0 + (taken - t0));

	dsc_host dut (
		.clk(clk), .rst_b(rst_b), .fast_mode(fast_mode),
		.req_valid(req_valid), .req_ready(req_ready), .req(req),
		.wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
		.rsp_valid(rsp_valid), .rsp(rsp), .ctl_select_n(ctl_select_n),
		.ctl_shift_clock(ctl_shift_clock),
		.ctl_serial_data_in(ctl_serial_data_in), .scl_i(scl_i),
		.scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_i(sda_i), .sda_o(sda_o),
		.sda_oe_n(sda_oe_n)
	);
	dsc_dev_model #(.DEV(2'h1)) dev_m (
		.ctl_select_n(ctl_select_n), .ctl_shift_clock(ctl_shift_clock),
		.ctl_serial_data_in(ctl_serial_data_in), .scl(scl_i),
		.sda(sda_i), .sda_pull(sda_pull)
	);

	always #5 clk = ~clk;
	always @(posedge clk) if (wr_valid && wr_ready) taken <= taken + 8'h01;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 90000) begin
			n_errors++;
			wrap_up();
		end
	end

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic idle_check();
		check({ctl_select_n, ctl_shift_clock, scl_oe_n, sda_oe_n,
			req_ready, wr_ready, rsp_valid, rsp.nack}, 8'hb8);
	endtask : idle_check

	task automatic run_row(input dsc_row_type r);
		logic [6:0] ca;
		int         i;
		ca = {r.rq.dev, r.rq.reg_base};
		@(negedge clk);
		fast_mode = r.fm;
		req = r.rq;
		d0 = r.d0;
		t0 = taken;
		req_valid = 1'h1;
		while (req_ready !== 1'h1) @(negedge clk);
		@(negedge clk);
		req_valid = 1'h0;
		while (rsp_valid !== 1'h1) @(negedge clk);
		check({7'h00, rsp.nack}, {7'h00, r.nk});
		check(8'(taken - t0), r.nb);
		if (r.rq.rd && !r.nk) check(rsp.rd_data, r.rdx);
		for (i = 0; i < int'(r.nb) && !r.clr; i++)
			check(dev_m.mem[7'(ca + i)], 8'(r.d0 + i));
		if (r.clr) check(dev_m.mem[ca], 8'h00);
	endtask : run_row

	task automatic wrap_up();
		$display("Checks %0d, errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : wrap_up

	initial begin
		clk = 1'h0;
		rst_b = 1'h0;
		fast_mode = 1'h1;
		req_valid = 1'h0;
		req = '0;
		wr_valid = 1'h1;
		d0 = 8'h00;
		t0 = 8'h00;
		rows = '{
			'{1'h1, '{1'h0,1'h0,2'h1,5'h10,4'h0}, 8'ha5, 8'h01, 1'h0, 8'h00, 1'h0},
			'{1'h1, '{1'h0,1'h0,2'h1,5'h11,4'hf}, 8'h50, 8'h0a, 1'h0, 8'h00, 1'h0},
			'{1'h1, '{1'h0,1'h0,2'h2,5'h12,4'h0}, 8'h77, 8'h01, 1'h0, 8'h00, 1'h1},
			'{1'h1, '{1'h1,1'h0,2'h1,5'h12,4'h1}, 8'h3c, 8'h02, 1'h0, 8'h00, 1'h0},
			'{1'h1, '{1'h1,1'h1,2'h1,5'h12,4'h0}, 8'h00, 8'h00, 1'h0, 8'h3c, 1'h0},
			'{1'h1, '{1'h1,1'h0,2'h1,5'h00,4'h0}, 8'h11, 8'h00, 1'h1, 8'h00, 1'h1},
			'{1'h0, '{1'h1,1'h1,2'h3,5'h10,4'h0}, 8'h00, 8'h00, 1'h1, 8'h00, 1'h0}
		};
		repeat (12) @(negedge clk);
		idle_check();
		rst_b = 1'h1;
		foreach (rows[k]) begin
			run_row(rows[k]);
			$display("Row %0d done", k);
		end
		// A reset in mid-frame must leave the old register content intact.
		@(negedge clk);
		req = '{1'h0, 1'h0, 2'h1, 5'h10, 4'h0};
		d0 = 8'h77;
		req_valid = 1'h1;
		while (ctl_select_n !== 1'h0) @(negedge clk);
		req_valid = 1'h0;
		repeat (60) @(negedge clk);
		rst_b = 1'h0;
		@(negedge clk);
		idle_check();
		rst_b = 1'h1;
		check(dev_m.mem[7'h30], 8'ha5);
		run_row(rows[0]);
		$display("Abort test done");
		// A late byte must stall either link without losing a bit.
		stall_row = rows[0];
		stall_row.d0 = 8'h5a;
		wr_valid = 1'h0;
		fork
			run_row(stall_row);
			begin
				repeat (400) @(negedge clk);
				wr_valid = 1'h1;
			end
		join
		stall_row = rows[3];
		stall_row.d0 = 8'h6b;
		wr_valid = 1'h0;
		fork
			run_row(stall_row);
			begin
				repeat (6000) @(negedge clk);
				wr_valid = 1'h1;
			end
		join
		$display("Stall test done");
		wrap_up();
	end
endmodule : test_dac_serial_control_port
`default_nettype wire
